/* design/uic_cnt_if.sv */
interface uic_cnt_if #(parameter int unsigned W = 16);
  logic en;
  logic load;
  logic down;
  logic step;
  logic [W-1:0] limit;
  logic [W-1:0] count;
  logic hit;
  modport ctl (output en, load, down, step, limit, input count, hit);
  modport cnt (input en, load, down, step, limit, output count, hit);
endinterface

/* design/uic_event_counter.sv */
module uic_event_counter #(
  parameter int unsigned W = uic_pkg::CNT_W
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  uic_cnt_if.cnt io_c
);
  typedef struct packed {
    logic [W-1:0] count;
    logic hit;
  } uic_ec_state_type;

  uic_ec_state_type q;
  uic_ec_state_type d;

  if (W < 2 || W > 32) begin : g_bad_w
    $error("uic_event_counter: W must lie in 2..32");
  end

  always_comb begin
    d = q;
    d.hit = 1'b0;
    if (io_c.load) begin
      d.count = io_c.down ? '1 : '0;
    end else if (io_c.en && io_c.step) begin
      d.count = io_c.down ? q.count - W'(1) : q.count + W'(1);
      d.hit = io_c.down ? (d.count == '0) : (d.count == io_c.limit);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign io_c.count = q.count;
  assign io_c.hit = q.hit;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_hold_when_off: assert property (!io_c.en && !io_c.load |=> $stable(q.count) && !q.hit)
    else $error("counter moved while disabled");
  a_up_step: assert property (io_c.en && io_c.step && !io_c.down && !io_c.load
    |=> q.count == $past(q.count) + W'(1))
    else $error("up counter did not advance by one");
  a_down_zero: assert property (q.hit && $past(io_c.down) |-> q.count == '0)
    else $error("down counter hit away from zero");
  c_limit_hit: cover property (q.hit);
endmodule

/* design/uic_pkg.sv */
package uic_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // A 0.5 us tick lets the 24-bit period count span about 8.4 s.
  localparam int unsigned TICK_NS = 500;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned GATE1_MS = 1000;
  localparam int unsigned GATE10_MS = 10000;
  localparam int unsigned GATE1_CYC = GATE1_MS * (CLK_HZ / 1000);
  localparam int unsigned GATE10_CYC = GATE10_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 16;
  localparam int unsigned MEAS_W = 24;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_EDGE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h0C;
  localparam logic [7:0] OFF_CNT0 = 8'h10;
  localparam logic [7:0] OFF_CNT1 = 8'h14;
  localparam logic [7:0] OFF_CNT2 = 8'h18;
  localparam logic [7:0] OFF_LIM0 = 8'h1C;
  localparam logic [7:0] OFF_LIM1 = 8'h20;
  localparam logic [7:0] OFF_LIM2 = 8'h24;
  localparam logic [7:0] OFF_MEAS = 8'h28;
  localparam logic [2:0] MODE_DIG = 3'h0;
  localparam logic [2:0] MODE_IRQ = 3'h1;
  localparam logic [2:0] MODE_CNT = 3'h2;
  localparam logic [2:0] MODE_FREQ = 3'h3;
  localparam logic [2:0] MODE_PER = 3'h4;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] GATE_OFF = 2'h0;
  localparam logic [1:0] GATE_1S = 2'h1;
  localparam int unsigned CTRL_EN_POS = 0;
  localparam int unsigned CTRL_DN_POS = 3;
  localparam int unsigned CTRL_GATE_POS = 6;
  localparam int unsigned CTRL_MEN_POS = 8;
  localparam logic [31:0] MASK_MODE = 32'h0000_0FFF;
  localparam logic [31:0] MASK_EDGE = 32'h0000_00FF;
  localparam logic [31:0] MASK_CTRL = 32'h0000_01FF;
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_EDGE = 32'h0000_0055;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* design/uic_timebase.sv */
module uic_timebase #(
  parameter int unsigned DIV = uic_pkg::TICK_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  output logic o_tick
);
  localparam int unsigned CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } uic_tb_state_type;

  uic_tb_state_type q;
  uic_tb_state_type d;

  if (DIV < 2) begin : g_bad_div
    $error("uic_timebase: DIV must be at least 2");
  end

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == CW'(DIV - 1)) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;
endmodule

/* design/uic_top.sv */
// Functional notes
// - There are four universal inputs; inputs one and two serve interrupt, digital or counting, input four only interrupt or digital.
// - Only input three adds frequency counting and period measurement to those uses.
// - An input set for interrupts pulses its interrupt line on the configured edge.
// - A digital input pushes nothing; its level is seen only when software reads it.
// - Counting keeps up with pulses of at least 10 kHz.
// - Each event counter counts up from 0 to 65535 or down from 65535 to 0, one per edge.
// - Each counter has one limit; up counting interrupts at the limit, down counting at zero.
// - The frequency counter counts pulses within a gate interval and reports the total.
// - The gate interval is selectable as 0 (off), 1 s or 10 s.
// - The period counter counts fixed ticks between two rising edges, range 0 to 16777215.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
module uic_top #(
  parameter int unsigned CNT_W = uic_pkg::CNT_W,
  parameter int unsigned MEAS_W = uic_pkg::MEAS_W,
  parameter int unsigned P_GATE1_CYC = uic_pkg::GATE1_CYC,
  parameter int unsigned P_GATE10_CYC = uic_pkg::GATE10_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [7:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  input wire logic [3:0] i_uin,
  output logic [3:0] o_irq_edge,
  output logic [2:0] o_irq_limit,
  output logic o_irq_freq,
  output logic o_irq_period
);
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] edge_cfg;
    logic [31:0] ctrl;
    logic [2:0][CNT_W-1:0] lim;
    logic [3:0] uin_p;
    logic [2:0] en_p;
    logic aw_ok;
    logic [7:0] aw_a;
    logic w_ok;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [1:0] rr;
    logic [31:0] rd;
    logic [3:0] irq_e;
    logic [31:0] gate_cnt;
    logic [MEAS_W-1:0] pl_cnt;
    logic [MEAS_W-1:0] tk_cnt;
    logic [MEAS_W-1:0] meas;
    logic armed;
    logic irq_f;
    logic irq_p;
  } uic_state_type;

  localparam uic_state_type S_RST = '{
    mode: uic_pkg::RST_MODE,
    edge_cfg: uic_pkg::RST_EDGE,
    ctrl: uic_pkg::RST_CTRL,
    default: '0
  };

  if (CNT_W < 2 || CNT_W > 32 || MEAS_W < 2 || MEAS_W > 32) begin : g_bad_w
    $error("uic_top: counter widths must lie in 2..32");
  end
  if (P_GATE1_CYC < 2 || P_GATE10_CYC < 2) begin : g_bad_gate
    $error("uic_top: gate lengths must be at least two cycles");
  end

  function automatic logic [2:0] eff_mode(input int unsigned idx, input logic [2:0] m);
    logic [2:0] top;
    top = (idx == 2) ? uic_pkg::MODE_PER : (idx == 3) ? uic_pkg::MODE_IRQ : uic_pkg::MODE_CNT;
    eff_mode = (m <= top) ? m : uic_pkg::MODE_DIG;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] && r) || (sel[1] && f);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
    end
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a[1:0] == 2'b00) && (a <= uic_pkg::OFF_MEAS);
  endfunction

  uic_state_type q;
  uic_state_type d;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0][2:0] eff;
  logic [2:0][CNT_W-1:0] cnt_val;
  logic [2:0] cnt_hit;
  logic [2:0] cnt_en;
  logic tick;
  logic [1:0] gate_sel;
  logic [31:0] gate_len;
  logic meas_on;
  logic [31:0] wv;
  logic [31:0] rv_word;

  assign rise = i_uin & ~q.uin_p;
  assign fall = ~i_uin & q.uin_p;
  assign gate_sel = q.ctrl[uic_pkg::CTRL_GATE_POS+:2];
  assign gate_len = (gate_sel == uic_pkg::GATE_1S) ? P_GATE1_CYC : P_GATE10_CYC;
  assign meas_on = q.ctrl[uic_pkg::CTRL_MEN_POS];

  uic_timebase #(
    .DIV(uic_pkg::TICK_CYC)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .o_tick(tick)
  );

  for (genvar g = 0; g < 4; g++) begin : g_in
    assign eff[g] = eff_mode(g, q.mode[3*g+:3]);
  end

  for (genvar g = 0; g < 3; g++) begin : g_cnt
    uic_cnt_if #(.W(CNT_W)) cif ();
    assign cnt_en[g] = q.ctrl[uic_pkg::CTRL_EN_POS + g] && (eff[g] == uic_pkg::MODE_CNT);
    assign cif.en = cnt_en[g];
    assign cif.load = cnt_en[g] && !q.en_p[g];
    assign cif.down = q.ctrl[uic_pkg::CTRL_DN_POS + g];
    assign cif.step = edge_hit(q.edge_cfg[2*g+:2], rise[g], fall[g]);
    assign cif.limit = q.lim[g];
    assign cnt_val[g] = cif.count;
    assign cnt_hit[g] = cif.hit;
    uic_event_counter #(
      .W(CNT_W)
    ) u_cnt (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .io_c(cif)
    );
  end

  always_comb begin
    case ({i_axi_araddr[7:2], 2'b00})
      uic_pkg::OFF_MODE: rv_word = q.mode;
      uic_pkg::OFF_EDGE: rv_word = q.edge_cfg;
      uic_pkg::OFF_CTRL: rv_word = q.ctrl;
      uic_pkg::OFF_LEVEL: rv_word = {28'h000_0000, i_uin};
      uic_pkg::OFF_CNT0: rv_word = 32'(cnt_val[0]);
      uic_pkg::OFF_CNT1: rv_word = 32'(cnt_val[1]);
      uic_pkg::OFF_CNT2: rv_word = 32'(cnt_val[2]);
      uic_pkg::OFF_LIM0: rv_word = 32'(q.lim[0]);
      uic_pkg::OFF_LIM1: rv_word = 32'(q.lim[1]);
      uic_pkg::OFF_LIM2: rv_word = 32'(q.lim[2]);
      uic_pkg::OFF_MEAS: rv_word = 32'(q.meas);
      default: rv_word = 32'h0000_0000;
    endcase
  end

  assign o_axi_awready = !q.aw_ok && !q.bv;
  assign o_axi_wready = !q.w_ok && !q.bv;
  assign o_axi_arready = !q.rv;

  always_comb begin
    d = q;
    d.uin_p = i_uin;
    d.en_p = cnt_en;
    d.irq_f = 1'b0;
    d.irq_p = 1'b0;
    wv = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      d.irq_e[i] = (eff[i] == uic_pkg::MODE_IRQ) &&
                   edge_hit(q.edge_cfg[2*i+:2], rise[i], fall[i]);
    end
    if (eff[2] == uic_pkg::MODE_FREQ && meas_on && gate_sel != uic_pkg::GATE_OFF) begin
      d.gate_cnt = q.gate_cnt + 32'h0000_0001;
      if (rise[2] && q.pl_cnt != '1) begin
        d.pl_cnt = q.pl_cnt + MEAS_W'(1);
      end
      if (q.gate_cnt == gate_len - 32'h0000_0001) begin
        d.meas = d.pl_cnt;
        d.pl_cnt = '0;
        d.gate_cnt = 32'h0000_0000;
        d.irq_f = 1'b1;
      end
    end else if (eff[2] == uic_pkg::MODE_PER && meas_on) begin
      if (tick && q.tk_cnt != '1) begin
        d.tk_cnt = q.tk_cnt + MEAS_W'(1);
      end
      if (rise[2]) begin
        if (q.armed) begin
          d.meas = q.tk_cnt;
          d.irq_p = 1'b1;
        end
        d.tk_cnt = '0;
        d.armed = 1'b1;
      end
    end else begin
      d.gate_cnt = 32'h0000_0000;
      d.pl_cnt = '0;
      d.tk_cnt = '0;
      d.armed = 1'b0;
    end
    // Address and data may arrive in either order; each is held until both are in.
    if (i_axi_awvalid && o_axi_awready) begin
      d.aw_ok = 1'b1;
      d.aw_a = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      d.w_ok = 1'b1;
      d.w_d = i_axi_wdata;
      d.w_s = i_axi_wstrb;
    end
    if (q.bv && i_axi_bready) begin
      d.bv = 1'b0;
    end
    if (d.aw_ok && d.w_ok && !q.bv) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bv = 1'b1;
      d.br = known(d.aw_a) ? uic_pkg::RESP_OKAY : uic_pkg::RESP_SLVERR;
      // A refused address selects no register, so an unaligned write cannot land in MODE.
      case (known(d.aw_a) ? d.aw_a : 8'hFF)
        uic_pkg::OFF_MODE: begin
          wv = merge(q.mode, d.w_d, d.w_s);
          d.mode = wv & uic_pkg::MASK_MODE;
        end
        uic_pkg::OFF_EDGE: begin
          wv = merge(q.edge_cfg, d.w_d, d.w_s);
          d.edge_cfg = wv & uic_pkg::MASK_EDGE;
        end
        uic_pkg::OFF_CTRL: begin
          wv = merge(q.ctrl, d.w_d, d.w_s);
          d.ctrl = wv & uic_pkg::MASK_CTRL;
        end
        uic_pkg::OFF_LIM0: begin
          wv = merge(32'(q.lim[0]), d.w_d, d.w_s);
          d.lim[0] = wv[CNT_W-1:0];
        end
        uic_pkg::OFF_LIM1: begin
          wv = merge(32'(q.lim[1]), d.w_d, d.w_s);
          d.lim[1] = wv[CNT_W-1:0];
        end
        uic_pkg::OFF_LIM2: begin
          wv = merge(32'(q.lim[2]), d.w_d, d.w_s);
          d.lim[2] = wv[CNT_W-1:0];
        end
        default: begin
          wv = 32'h0000_0000;
        end
      endcase
    end
    if (q.rv && i_axi_rready) begin
      d.rv = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready) begin
      d.rv = 1'b1;
      d.rd = known(i_axi_araddr) ? rv_word : 32'h0000_0000;
      d.rr = known(i_axi_araddr) ? uic_pkg::RESP_OKAY : uic_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= S_RST;
    end else begin
      q <= d;
    end
  end

  assign o_axi_bvalid = q.bv;
  assign o_axi_bresp = q.br;
  assign o_axi_rvalid = q.rv;
  assign o_axi_rdata = q.rd;
  assign o_axi_rresp = q.rr;
  assign o_irq_edge = q.irq_e;
  assign o_irq_limit = cnt_hit;
  assign o_irq_freq = q.irq_f;
  assign o_irq_period = q.irq_p;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_in4_no_count: assert property (q.mode[11:9] >= uic_pkg::MODE_CNT |->
    eff[3] == uic_pkg::MODE_DIG)
    else $error("input four took a counting function");
  a_meas_in3_only: assert property (o_irq_freq || o_irq_period |->
    $past(q.mode[8:6]) >= uic_pkg::MODE_FREQ)
    else $error("measurement event without input three measuring");
  a_edge_irq_rise: assert property (eff[0] == uic_pkg::MODE_IRQ &&
    q.edge_cfg[1:0] == uic_pkg::EDGE_RISE && i_uin[0] && !q.uin_p[0] |=> o_irq_edge[0])
    else $error("rising edge gave no interrupt");
  a_digital_quiet: assert property (eff[1] == uic_pkg::MODE_DIG |=>
    !o_irq_edge[1] && !o_irq_limit[1])
    else $error("digital input raised an event");
  a_gate_close: assert property (o_irq_freq && $past(gate_sel) == uic_pkg::GATE_1S |->
    $past(q.gate_cnt) == P_GATE1_CYC - 1)
    else $error("frequency gate closed at the wrong count");
  a_gate_off: assert property (gate_sel == uic_pkg::GATE_OFF |=> !o_irq_freq)
    else $error("frequency result with gate off");
  a_period_cap: assert property (o_irq_period |-> q.meas == $past(q.tk_cnt) &&
    $past(rise[2]))
    else $error("period result not the tick count at a rise");
  a_enable_gate: assert property (!cnt_en[2] |=> !o_irq_limit[2])
    else $error("disabled counter raised its limit event");
  c_freq_done: cover property (o_irq_freq);
  c_period_done: cover property (o_irq_period);
  c_edge_irq: cover property (o_irq_edge[3]);
  c_limit_any: cover property (|o_irq_limit);
endmodule

/* testbench/test_universal_input_counters.sv */
module test_universal_input_counters;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_mclk, i_rstn, awvalid, wvalid, bready, arvalid, rready, clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0] o_axi_bresp, o_axi_rresp;
  logic [31:0] o_axi_rdata;
  logic [3:0] uin, o_irq_edge;
  logic [2:0] o_irq_limit;
  logic o_irq_freq, o_irq_period;
  int n_errors = 0;
  int check_count = 0;
  int n_edge [4];
  int n_lim [3];
  int n_freq, n_per;

  uic_top #(.P_GATE1_CYC(100), .P_GATE10_CYC(1000)) u_uic_top (
    .i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_axi_awvalid(awvalid), .o_axi_awready(o_axi_awready), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wvalid), .o_axi_wready(o_axi_wready), .i_axi_wdata(wdata),
    .i_axi_wstrb(wstrb), .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(bready),
    .o_axi_bresp(o_axi_bresp), .i_axi_arvalid(arvalid), .o_axi_arready(o_axi_arready),
    .i_axi_araddr(araddr), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(rready),
    .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp), .i_uin(uin),
    .o_irq_edge(o_irq_edge), .o_irq_limit(o_irq_limit), .o_irq_freq(o_irq_freq),
    .o_irq_period(o_irq_period));

  uic_sensor_model u_uic_sensor_model (.i_mclk(i_mclk), .o_uin(uin));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (clr) begin
      n_edge = '{0, 0, 0, 0};
      n_lim = '{0, 0, 0};
      n_freq = 0;
      n_per = 0;
    end else begin
      for (int i = 0; i < 4; i++) if (o_irq_edge[i] === 1'b1) n_edge[i]++;
      for (int i = 0; i < 3; i++) if (o_irq_limit[i] === 1'b1) n_lim[i]++;
      if (o_irq_freq === 1'b1) n_freq++;
      if (o_irq_period === 1'b1) n_per++;
    end
  end

  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout;
    n_errors++;
    $display("Error wait bound exceeded");
    report_and_stop();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] exp_edges(input logic [1:0] c, input int n);
    return (c[0] ? n : 0) + (c[1] ? n : 0);
  endfunction

  function automatic logic [31:0] exp_count(input logic down, input int n);
    return down ? 32'h0000_FFFF - n : n;
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    n = 0;
    while ((aw || w) && n < 100) begin
      @(posedge i_mclk);
      n++;
      if (aw && o_axi_awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && o_axi_wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    if (n >= 100) timeout();
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_axi_bvalid !== 1'b1 && n < 100);
    if (n >= 100) timeout();
    r = o_axi_bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    arvalid <= 1'b1;
    araddr <= a;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_axi_arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    if (n >= 100) timeout();
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_axi_rvalid !== 1'b1 && n < 100);
    if (n >= 100) timeout();
    d = o_axi_rdata;
    r = o_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, uic_pkg::RESP_OKAY});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(nm, d, e);
  endtask

  task automatic clear_mon;
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
  endtask

  task automatic wait_freq(output int c);
    c = 0;
    do begin
      @(posedge i_mclk);
      c++;
    end while (o_irq_freq !== 1'b1 && c < 2500);
    if (c >= 2500) timeout();
  endtask

  initial begin
    logic [31:0] d, e, lv;
    logic [1:0] r;
    int n, m, c, p;
    i_rstn = 1'b0;
    {awvalid, wvalid, arvalid, clr} = 4'h0;
    {bready, rready} = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    void'($urandom(32'h5ddc));
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    rd_chk("mode_rst", uic_pkg::OFF_MODE, uic_pkg::RST_MODE);
    rd_chk("edge_rst", uic_pkg::OFF_EDGE, uic_pkg::RST_EDGE);
    rd_chk("ctrl_rst", uic_pkg::OFF_CTRL, uic_pkg::RST_CTRL);
    axi_read(8'h2C, d, r);
    check("unmapped_rresp", {30'h0, r}, {30'h0, uic_pkg::RESP_SLVERR});
    check("unmapped_rdata", d, 32'h0000_0000);
    axi_write(8'h01, 32'h0000_0001, r);
    check("unaligned_bresp", {30'h0, r}, {30'h0, uic_pkg::RESP_SLVERR});
    rd_chk("unaligned_ignored", uic_pkg::OFF_MODE, uic_pkg::RST_MODE);
    clear_mon();
    for (int k = 0; k < 3; k++) begin
      lv = $urandom;
      u_uic_sensor_model.set_level(lv[3:0]);
      repeat (2) @(posedge i_mclk);
      rd_chk("level", uic_pkg::OFF_LEVEL, {28'h0, lv[3:0]});
    end
    u_uic_sensor_model.set_level(4'h0);
    repeat (3) @(posedge i_mclk);
    for (int i = 0; i < 4; i++) check("digital_irq", n_edge[i], 32'h0000_0000);
    wr(uic_pkg::OFF_MODE, 32'h0000_0249);
    wr(uic_pkg::OFF_EDGE, 32'h0000_0079);
    clear_mon();
    n = 1 + $urandom % 8;
    for (int i = 0; i < 4; i++) u_uic_sensor_model.pulse(i, n, 2, 3);
    repeat (4) @(posedge i_mclk);
    for (int i = 0; i < 4; i++) begin
      lv = 32'h0000_0079 >> (2 * i);
      check("irq_edge", n_edge[i], exp_edges(lv[1:0], n));
    end
    n = 1 + $urandom % 8;
    m = 1 + $urandom % 8;
    wr(uic_pkg::OFF_MODE, 32'h0000_0412);
    wr(uic_pkg::OFF_EDGE, 32'h0000_0055);
    wr(uic_pkg::OFF_LIM0, n);
    clear_mon();
    u_uic_sensor_model.pulse(0, 3, 2, 2);
    rd_chk("cnt0_idle", uic_pkg::OFF_CNT0, 32'h0000_0000);
    check("lim_idle", n_lim[0], 32'h0000_0000);
    wr(uic_pkg::OFF_CTRL, 32'h0000_0013);
    repeat (2) @(posedge i_mclk);
    u_uic_sensor_model.pulse(0, n, 2, 2);
    u_uic_sensor_model.pulse(1, m, 2, 2);
    u_uic_sensor_model.pulse(3, 2, 2, 2);
    repeat (3) @(posedge i_mclk);
    rd_chk("cnt0_up", uic_pkg::OFF_CNT0, exp_count(1'b0, n));
    check("lim0_hit", n_lim[0], 32'h0000_0001);
    rd_chk("cnt1_down", uic_pkg::OFF_CNT1, exp_count(1'b1, m));
    check("lim1_quiet", n_lim[1], 32'h0000_0000);
    check("in4_no_counter", n_edge[3], 32'h0000_0000);
    wr(uic_pkg::OFF_CTRL, 32'h0000_0000);
    u_uic_sensor_model.pulse(0, 2, 2, 2);
    rd_chk("cnt0_frozen", uic_pkg::OFF_CNT0, exp_count(1'b0, n));
    wr(uic_pkg::OFF_MODE, 32'h0000_00C0);
    wr(uic_pkg::OFF_CTRL, 32'h0000_0140);
    wait_freq(c);
    n = 1 + $urandom % 6;
    u_uic_sensor_model.pulse(2, n, 4, 4);
    wait_freq(c);
    rd_chk("freq_count", uic_pkg::OFF_MEAS, n);
    for (int g = 1; g < 4; g++) begin
      wr(uic_pkg::OFF_CTRL, 32'h0000_0100 | (g << 6));
      wait_freq(c);
      wait_freq(c);
      check("gate_len", c, (g == 1) ? 32'h0000_0064 : 32'h0000_03E8);
    end
    wr(uic_pkg::OFF_CTRL, 32'h0000_0100);
    repeat (10) @(posedge i_mclk);
    clear_mon();
    repeat (1500) @(posedge i_mclk);
    check("gate_off", n_freq, 32'h0000_0000);
    wr(uic_pkg::OFF_MODE, 32'h0000_0100);
    clear_mon();
    p = 300 + $urandom % 500;
    u_uic_sensor_model.pulse(2, 3, p / 2, p - p / 2);
    repeat (5) @(posedge i_mclk);
    axi_read(uic_pkg::OFF_MEAS, d, r);
    // The rise itself clears the tick count, so only the p - 1 cycles after it add ticks.
    e = (p - 1) / uic_pkg::TICK_CYC;
    check("period_ticks", {31'h0, (d === e) || (d === e + 1)}, 32'h0000_0001);
    check("period_irqs", n_per, 32'h0000_0002);
    check("r2_in3_only", n_edge[2], 32'h0000_0000);
    report_and_stop();
  end
endmodule

/* testbench/uic_sensor_model.sv */
module uic_sensor_model (
  input wire logic i_mclk,
  output logic [3:0] o_uin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_uin = 4'h0;

  // Pulses run far faster than the slowest rate the counters must follow.
  // fast pulse train
  task automatic pulse(input int ch, input int n, input int hi, input int lo);
    repeat (n) begin
      o_uin[ch] <= 1'b1;
      repeat (hi) @(posedge i_mclk);
      o_uin[ch] <= 1'b0;
      repeat (lo) @(posedge i_mclk);
    end
  endtask

  task automatic set_level(input logic [3:0] v);
    o_uin <= v;
    @(posedge i_mclk);
  endtask
endmodule
